// [rtl/fspc_ctrl.sv]
// Host controller driving sector protect, unprotect and verify on flash pins
//
// Summary of operation
// - Protect mode: high voltage on address bit nine and OE, bit six low, CE low.
// - Verify: high voltage on bit nine, CE OE low, WE high, bit one high.
// - Unprotect mode: high voltage on OE and bit nine, CE low, bit six high.
// - Host should protect all sectors before unprotecting the chip; OP_UNPROTECT does not, it leaves this to software.
// - Write cycle needs CE and WE low and OE high.
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int UNPROT_CYCLES = UNPROT_CYC
) (
  input  wire logic                         sys_clk,    // System clock
  input  wire logic                         srst,       // Sync reset, high
  input  wire logic                         req,        // Start operation
  input  wire logic [1:0]                   op,         // Operation code
  input  wire logic [fspc_pkg::SECT_W-1:0]  sector,     // Target sector
  output logic                              busy,       // Operation running
  output logic                              done,       // One-cycle finish
  output logic                              is_protected, // Verify result
  output logic [fspc_pkg::DATA_W-1:0]       rd_data,    // Byte read back
  output logic [fspc_pkg::ADDR_W-1:0]       flash_addr, // Address pins
  output logic                              high_voltage_level_nine, // HV A9
  output logic                              high_voltage_level_oe,   // HV OE
  output logic                              ce_n,       // Chip select
  output logic                              oe_n,       // Output enable
  output logic                              we_n,       // Write strobe
  output logic [fspc_pkg::DATA_W-1:0]       dq_out,     // Data out
  output logic                              dq_oe_n,    // Data drive, low on
  input  wire logic [fspc_pkg::DATA_W-1:0]  dq_in       // Data in
);
  fspc_state_t       state_q;
  logic [1:0]        op_q;
  logic [SECT_W-1:0] sect_q;
  logic [2:0]        cmd_idx_q;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_count;
  logic              tmr_done;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic              is_hv_op;
  logic              is_write_op;

  assign is_hv_op    = (op_q != OP_ID_VERIFY);
  assign is_write_op = (op_q == OP_PROTECT) || (op_q == OP_UNPROTECT);

  fspc_timer #(.CNT_W(CNT_W)) u_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_done)
  );

  // Two-stage synchroniser for the data pins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // Identification command bytes; last one returns device to read mode
  always_comb begin
    cmd_addr = CMD_ADDR_A;
    cmd_data = CMD_DATA_A;
    case (cmd_idx_q)
      3'h0: begin
        cmd_addr = CMD_ADDR_A;
        cmd_data = CMD_DATA_A;
      end
      3'h1: begin
        cmd_addr = CMD_ADDR_B;
        cmd_data = CMD_DATA_B;
      end
      3'h2: begin
        cmd_addr = CMD_ADDR_A;
        cmd_data = CMD_ID;
      end
      default: begin
        cmd_addr = CMD_ADDR_A;
        cmd_data = CMD_RESET;
      end
    endcase
  end

  // Timer load on each phase entry
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_q)
      FSPC_IDLE: begin
        tmr_load  = req;
        tmr_count = CNT_W'(SETUP_CYC);
      end
      FSPC_SETUP: begin
        tmr_load  = tmr_done;
        if (op_q == OP_UNPROTECT) begin // Software protects all first
          tmr_count = CNT_W'(UNPROT_CYCLES);
        end else if (op_q == OP_PROTECT) begin
          tmr_count = CNT_W'(PROT_CYC);
        end else begin
          tmr_count = CNT_W'(READ_CYC);
        end
      end
      FSPC_CMDLO, FSPC_CMDHI, FSPC_PULSE, FSPC_READ: begin
        tmr_load  = tmr_done;
        tmr_count = CNT_W'(READ_CYC);
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // Phase sequencing
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q   <= FSPC_IDLE;
      op_q      <= OP_PROTECT;
      sect_q    <= '0;
      cmd_idx_q <= '0;
    end else begin
      case (state_q)
        FSPC_IDLE: begin
          cmd_idx_q <= '0;
          if (req) begin
            op_q    <= op;
            sect_q  <= sector;
            state_q <= FSPC_SETUP;
          end
        end
        FSPC_SETUP: begin
          if (tmr_done) begin
            if (is_write_op) begin
              state_q <= FSPC_PULSE;
            end else if (op_q == OP_ID_VERIFY) begin
              state_q <= FSPC_CMDLO;
            end else begin
              state_q <= FSPC_READ;
            end
          end
        end
        FSPC_CMDLO: begin
          if (tmr_done) begin
            state_q <= FSPC_CMDHI;
          end
        end
        FSPC_CMDHI: begin
          if (tmr_done) begin
            cmd_idx_q <= cmd_idx_q + 3'h1;
            if (cmd_idx_q == CMD_LEN - 3'h2) begin
              state_q <= FSPC_READ;
            end else if (cmd_idx_q == CMD_LEN - 3'h1) begin
              state_q <= FSPC_DONE;
            end else begin
              state_q <= FSPC_CMDLO;
            end
          end
        end
        FSPC_PULSE: begin
          if (tmr_done) begin
            state_q <= FSPC_RELS;
          end
        end
        FSPC_READ: begin
          if (tmr_done) begin
            state_q <= (op_q == OP_ID_VERIFY) ? FSPC_CMDLO : FSPC_RELS;
          end
        end
        FSPC_RELS: begin
          state_q <= FSPC_DONE;
        end
        FSPC_DONE: begin
          state_q <= FSPC_IDLE;
        end
        default: begin
          state_q <= FSPC_IDLE;
        end
      endcase
    end
  end

  // Address, high voltage and strobe pins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flash_addr              <= '0;
      high_voltage_level_nine <= 1'b0;
      high_voltage_level_oe   <= 1'b0;
      ce_n                    <= 1'b1;
      oe_n                    <= 1'b1;
      we_n                    <= 1'b1;
      dq_out                  <= '0;
      dq_oe_n                 <= 1'b1;
    end else begin
      flash_addr <= '0;
      flash_addr[SECT_LSB +: SECT_W] <= sect_q;
      high_voltage_level_nine <= 1'b0;
      high_voltage_level_oe   <= 1'b0;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      dq_oe_n <= 1'b1;
      dq_out  <= cmd_data;
      case (state_q)
        FSPC_SETUP, FSPC_PULSE: begin
          if (is_hv_op) begin
            high_voltage_level_nine <= 1'b1;
            ce_n <= 1'b0;
            // Bit six low protects, high unprotects
            flash_addr[ADDR_BIT_SIX] <= (op_q == OP_UNPROTECT);
            if (is_write_op) begin
              high_voltage_level_oe <= 1'b1;
              // CE already low: WE falling edge starts, rising ends
              we_n <= (state_q != FSPC_PULSE);
            end else begin
              oe_n <= (state_q != FSPC_SETUP) ? 1'b0 : 1'b1;
              flash_addr[ADDR_BIT_ONE] <= 1'b1;
            end
          end
        end
        FSPC_CMDLO: begin
          flash_addr <= cmd_addr;
          ce_n    <= 1'b0;
          we_n    <= 1'b0;
          dq_oe_n <= 1'b0;
        end
        FSPC_CMDHI: begin
          flash_addr <= cmd_addr;
          dq_oe_n    <= 1'b0;
        end
        FSPC_READ: begin
          ce_n <= 1'b0;
          oe_n <= 1'b0;
          flash_addr[ADDR_BIT_ONE] <= 1'b1;
          high_voltage_level_nine <= is_hv_op;
        end
        default: begin
          dq_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Status and read-back capture
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy        <= 1'b0;
      done        <= 1'b0;
      is_protected <= 1'b0;
      rd_data     <= '0;
    end else begin
      busy <= (state_q != FSPC_IDLE) || req;
      done <= (state_q == FSPC_DONE);
      if (state_q == FSPC_READ && tmr_done) begin
        rd_data     <= dq_s2_q;
        // Bit zero high means protected, zero byte unprotected
        is_protected <= dq_s2_q[0];
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/fspc_pkg.sv]
// Package of constants for the flash sector protect controller
package fspc_pkg;
  localparam int ADDR_W        = 19;
  localparam int DATA_W        = 8;
  localparam int SECT_W        = 3;
  localparam int SECT_LSB      = 16;
  localparam int ADDR_BIT_SIX  = 6;
  localparam int ADDR_BIT_ONE  = 1;
  localparam int ADDR_BIT_NINE = 9;
  // Operation codes on the command port
  localparam logic [1:0] OP_PROTECT   = 2'h0;
  localparam logic [1:0] OP_UNPROTECT = 2'h1;
  localparam logic [1:0] OP_VERIFY    = 2'h2;
  localparam logic [1:0] OP_ID_VERIFY = 2'h3;
  // Times in their own units
  localparam int CLK_PERIOD_NS    = 20;
  localparam int SETUP_TIME_NS    = 4000;
  localparam int PROT_PULSE_NS    = 10000;
  localparam int UNPROT_PULSE_NS  = 12000000;
  localparam int READ_TIME_NS     = 120;
  localparam int SETUP_CYC  = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROT_CYC   = (PROT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNPROT_CYC = (UNPROT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC   = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 24;
  // Command sequence for the identification read
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 19'h0_0555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 19'h0_02AA;
  localparam logic [DATA_W-1:0] CMD_DATA_A = 8'hAA;
  localparam logic [DATA_W-1:0] CMD_DATA_B = 8'h55;
  localparam logic [DATA_W-1:0] CMD_ID     = 8'h90;
  localparam logic [DATA_W-1:0] CMD_RESET  = 8'hF0;
  localparam logic [2:0]        CMD_LEN    = 3'h4;
  // Controller states, one-hot
  typedef enum logic [7:0] {
    FSPC_IDLE  = 8'b0000_0001,
    FSPC_SETUP = 8'b0000_0010,
    FSPC_PULSE = 8'b0000_0100,
    FSPC_READ  = 8'b0000_1000,
    FSPC_CMDLO = 8'b0001_0000,
    FSPC_CMDHI = 8'b0010_0000,
    FSPC_RELS  = 8'b0100_0000,
    FSPC_DONE  = 8'b1000_0000
  } fspc_state_t;
endpackage

// [rtl/fspc_timer.sv]
// Down counter that times each pin phase of the controller
`timescale 1ns/1ps
`default_nettype none
module fspc_timer #(
  parameter int CNT_W = 24
) (
  input  wire logic             sys_clk,  // System clock
  input  wire logic             srst,     // Synchronous reset
  input  wire logic             load,     // Load a new count
  input  wire logic [CNT_W-1:0] count,    // Cycles to wait
  output logic                  expired   // Count reached zero
);
  logic [CNT_W-1:0] cnt_q;

  // Load or count down
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // Plain zero test; the load path feeds back on this, so no load term here
  assign expired = (cnt_q == '0);
endmodule
`default_nettype wire

// [testbench/fspc_ctrl_sva.sv]
// Checker of pin sequencing for the sector protect controller
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_sva
  import fspc_pkg::*;
#(
  parameter int UNPROT_CYCLES = UNPROT_CYC
) (
  input wire logic                       sys_clk,    // Clock
  input wire logic                       srst,       // Reset
  input wire logic                       busy,       // Running
  input wire logic                       done,       // Finish
  input wire logic [fspc_pkg::ADDR_W-1:0] flash_addr, // Address
  input wire logic high_voltage_level_nine,           // HV on bit nine
  input wire logic high_voltage_level_oe,             // HV on OE
  input wire logic                       ce_n,       // Select
  input wire logic                       oe_n,       // Out enable
  input wire logic                       we_n,       // Strobe
  input wire logic                       dq_oe_n     // Data drive
);
  logic hv_sel;
  // Both high-voltage levels with the chip selected
  assign hv_sel = high_voltage_level_nine && high_voltage_level_oe && !ce_n;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Start and hold of a high-voltage write pulse
  sequence s_hv_start;
    $fell(we_n) && high_voltage_level_oe;
  endsequence
  sequence s_pulse_held;
    !we_n [*8];
  endsequence
  a_protect_mode_pins: assert property (
    !we_n && high_voltage_level_oe && !flash_addr[ADDR_BIT_SIX] |-> hv_sel)
    else $error("protect pulse without mode pins");
  a_unprot_mode_pins: assert property (
    !we_n && high_voltage_level_oe && flash_addr[ADDR_BIT_SIX] |-> hv_sel)
    else $error("unprotect pulse without mode pins");
  a_hv_setup_held: assert property (
    s_hv_start |-> $past(hv_sel, 8))
    else $error("high voltage not set up before pulse");
  a_hv_pulse_width: assert property (
    s_hv_start |-> s_pulse_held)
    else $error("high voltage pulse too short");
  a_read_pins: assert property (
    !oe_n && !ce_n && !high_voltage_level_oe
    |-> we_n && flash_addr[ADDR_BIT_ONE] && dq_oe_n)
    else $error("read cycle with wrong pins");
  a_write_oe_high: assert property (
    !we_n && !ce_n && !high_voltage_level_oe |-> oe_n && !dq_oe_n)
    else $error("command write with OE low");
  a_idle_released: assert property (
    !busy && !done |-> ce_n && we_n && dq_oe_n
    && !high_voltage_level_nine && !high_voltage_level_oe)
    else $error("pins not released while idle");
  a_done_single: assert property (
    done |=> !done)
    else $error("done longer than one cycle");
endmodule
bind fspc_ctrl fspc_ctrl_sva #(.UNPROT_CYCLES(UNPROT_CYCLES)) u_sva (
  .sys_clk, .srst, .busy, .done, .flash_addr, .high_voltage_level_nine,
  .high_voltage_level_oe, .ce_n, .oe_n, .we_n, .dq_oe_n);
`default_nettype wire

// [testbench/fspc_flash_model.sv]
// Behavioural flash device with sector protect flags
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model
  import fspc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'hC3  // Arbitrary value
) (
  input wire logic                       sys_clk,  // Sampling clock
  input wire logic [fspc_pkg::ADDR_W-1:0] addr,    // Address pins
  input wire logic                       hv_nine,  // HV on bit nine
  input wire logic                       hv_oe,    // HV on OE
  input wire logic                       ce_n,     // Select
  input wire logic                       oe_n,     // Out enable
  input wire logic                       we_n,     // Strobe
  input wire logic [7:0]                 dq_out,   // Host data
  input wire logic                       dq_oe_n,  // Host drives
  output wire logic [7:0]                dq_in     // Bus level
);
  logic [7:0]  prot_q, rd_val, last_q, exp_d;
  logic [28:0] lat_q;
  logic        id_mode, wr_on, wr_prev, rd_on;
  int          seq;
  // Power-up in array read, nothing pending
  initial begin
    prot_q = '0;
    id_mode = 1'b0;
    seq = 0;
    last_q = '0;
    wr_prev = 1'b0;
  end
  // Write window opens on the later falling strobe, shuts on a rise
  assign wr_on = !ce_n && !we_n && (oe_n || hv_oe);
  assign rd_on = !ce_n && !oe_n && we_n;
  // Status byte in verify or ID mode; array is never rewritten here
  assign rd_val = !(hv_nine || id_mode) ? 8'hFF :
    addr[ADDR_BIT_ONE] ? {7'h0, prot_q[addr[SECT_LSB +: SECT_W]]} :
    addr[0] ? PART_ID : MAKER_ID;
  // Released bus shows the inverse of the last byte
  assign dq_in = !dq_oe_n ? dq_out : rd_on ? rd_val : ~last_q;
  always @(rd_on or rd_val) if (rd_on) last_q = rd_val;
  // Latch the write, act when the window closes
  always @(negedge sys_clk) begin
    wr_prev <= wr_on;
    if (wr_on) lat_q <= {hv_nine && hv_oe, addr[ADDR_BIT_SIX], addr[18:16],
                         addr[10:0], 5'h0, dq_in};
    exp_d = (seq == 0) ? CMD_DATA_A : (seq == 1) ? CMD_DATA_B : CMD_ID;
    if (wr_prev && !wr_on) begin
      if (lat_q[28] && lat_q[27]) prot_q <= '0;
      else if (lat_q[28]) prot_q[lat_q[26:24]] <= 1'b1;
      else if (lat_q[7:0] == CMD_RESET) begin
        id_mode <= 1'b0;
        seq <= 0;
      end else if (lat_q[7:0] == exp_d && lat_q[23:13] ==
                   ((seq == 1) ? CMD_ADDR_B[10:0] : CMD_ADDR_A[10:0])) begin
        seq <= (seq == 2) ? 0 : seq + 1;
        if (seq == 2) id_mode <= 1'b1;
      end else seq <= 0;
    end
  end
endmodule
`default_nettype wire

// [testbench/fspc_ctrl_bench.sv]
// Self-checking bench for the sector protect controller
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_bench;
  import fspc_pkg::*;
  logic        sys_clk = 0, srst = 1, req = 0;
  logic [1:0]  op = '0;
  logic [2:0]  sector = '0;
  logic        busy, done, is_protected, hv9, hvoe, ce_n, oe_n, we_n, dq_oe_n;
  logic [7:0]  rd_data, dq_out, dq_in;
  logic [18:0] flash_addr;
  int          n_errors = 0, n_checks = 0;
  // Clock and design under test
  always #10 sys_clk = ~sys_clk;
  fspc_ctrl #(.UNPROT_CYCLES(50)) dut_u (.sys_clk, .srst, .req, .op,
    .sector, .busy, .done, .is_protected, .rd_data, .flash_addr,
    .high_voltage_level_nine(hv9), .high_voltage_level_oe(hvoe), .ce_n,
    .oe_n, .we_n, .dq_out, .dq_oe_n, .dq_in);
  fspc_flash_model u_flash (.sys_clk, .addr(flash_addr), .hv_nine(hv9),
    .hv_oe(hvoe), .ce_n, .oe_n, .we_n, .dq_out, .dq_oe_n, .dq_in);
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pulse a request for one cycle
  task automatic start(logic [1:0] o, logic [2:0] s);
    @(negedge sys_clk);
    req = 1'b1;
    op = o;
    sector = s;
    @(negedge sys_clk);
    req = 1'b0;
  endtask
  // Bounded wait for the finish pulse
  task automatic wait_done();
    int i;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge sys_clk);
    chk_bit("done", 1'b1, done);
    if (done !== 1'b1) stop_test();
  endtask
  task automatic verify(logic [1:0] o, logic [2:0] s, logic prot);
    start(o, s);
    wait_done();
    chk_bit("is_protected", prot, is_protected);
    chk_byte("rd_data", {7'h0, prot}, rd_data);
  endtask
  task automatic sc_idle();
    chk_bit("busy", 1'b0, busy);
    chk_bit("ce_n", 1'b1, ce_n);
    chk_bit("hv9", 1'b0, hv9);
    chk_bit("hvoe", 1'b0, hvoe);
    chk_bit("dq_oe_n", 1'b1, dq_oe_n);
  endtask
  task automatic sc_protect_read();
    start(OP_PROTECT, 3'h3);
    wait_done();
    verify(OP_VERIFY, 3'h3, 1'b1);
    verify(OP_VERIFY, 3'h2, 1'b0);
    verify(OP_ID_VERIFY, 3'h3, 1'b1);
    verify(OP_ID_VERIFY, 3'h2, 1'b0);
  endtask
  task automatic sc_busy_refused();
    int i;
    start(OP_PROTECT, 3'h6);
    for (i = 0; i < 4; i++) start(OP_UNPROTECT, 3'h0);
    wait_done();
    repeat (30) begin
      @(negedge sys_clk);
      chk_bit("done_extra", 1'b0, done);
    end
    verify(OP_VERIFY, 3'h6, 1'b1);
  endtask
  task automatic sc_unprotect_all();
    int s;
    for (s = 0; s < 8; s++) begin
      start(OP_PROTECT, 3'(s));
      wait_done();
    end
    verify(OP_VERIFY, 3'h7, 1'b1);
    start(OP_UNPROTECT, 3'h2);
    wait_done();
    for (s = 0; s < 8; s++) verify(OP_VERIFY, 3'(s), 1'b0);
    verify(OP_ID_VERIFY, 3'h0, 1'b0);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    sc_idle();
    sc_protect_read();
    sc_busy_refused();
    sc_unprotect_all();
    stop_test();
  end
endmodule
`default_nettype wire
